// *** bpm_top.sv ***
/*
  Breakpoint control and match logic for four hardware breakpoints, with APB registers.
  Assumes the core pipeline drives access, task-switch, debug-register-move and
  handler-entry indications synchronously on pclk, and holds a flagged instruction.
*/
// Contract
// - Local enables at even control bits raise the exception on a condition.
// - Every task switch clears all local enables.
// - Global enables at odd bits raise the exception and survive task switches.
// - Exact enable bits are stored but do not affect detection.
// - With protection set, a debug-register move raises the exception first.
// - Protected access sets the detected status flag on the same edge as the exception.
// - Entering the handler clears the protection bit.
// - Access-type fields sit at bit 16 and every four bits above.
// - Types decode as execute, write, I/O, read-or-write with extensions.
// - Without extensions the I/O code is undefined.
// - Length fields above each type: one, two or four bytes.
// - Length code two means eight bytes only where supported.
// - Length masks low breakpoint address bits for alignment.
// - Port addresses are zero-extended to 32 bits for comparison.
// - Any touched byte inside the range signals a data breakpoint.
// - Execute breakpoints match only the first byte of an instruction.
// - On an exception, status bits zero to three flag each met condition.
`timescale 1ns/1ps
`default_nettype none
module bpm_top
  import bpm_pkg::*;
#(
  parameter bit LEN8_SUPPORTED = 1'b1,
  parameter int unsigned NUM_BP = BPM_NUM_BP
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core pipeline.
  input wire bpm_acc_s acc,
  input wire logic task_switch,
  input wire logic dbg_reg_move,
  input wire logic handler_entry,
  // Results.
  output logic debug_exception,
  output logic [NUM_BP-1:0] bkpt_hit_flag,
  output logic irq
);
  logic [31:0] bkpt_addr_r [NUM_BP];
  logic [31:0] breakpoint_control_r;
  logic [31:0] debug_status_reg_r;
  logic [31:0] cfg_r;
  logic [31:0] last_addr_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic debug_exception_r;
  logic [NUM_BP-1:0] hit_r;
  logic [NUM_BP-1:0] cond;
  logic [NUM_BP-1:0] enabled;
  logic [NUM_BP-1:0] fire;
  logic [BPM_NUM_EVT-1:0] evt;
  logic [BPM_NUM_EVT-1:0] evt_stat;
  logic [BPM_NUM_EVT-1:0] evt_mask;
  logic evt_irq;
  logic wr_en;
  logic bp_exc;
  logic reg_exc;
  logic ext_en;
  logic is_addr;
  logic [1:0] addr_idx;
  logic [31:0] rd_mux;
  logic rd_err;

  assign ext_en = cfg_r[BPM_CFG_EXT_EN];
  assign is_addr = (paddr <= BPM_OFS_ADDR3) && (paddr[1:0] == 2'h0);
  assign addr_idx = paddr[3:2];
  // Writes take effect on the edge that completes the access phase.
  assign wr_en = psel && penable && pready_r && pwrite;

  // Per-breakpoint matchers, all judged in the same cycle.
  generate
    for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
      bpm_match #(
        .LEN8_SUPPORTED(LEN8_SUPPORTED)
      ) u_match (
        .bp_addr(bkpt_addr_r[i]),
        .type_field(breakpoint_control_r[BPM_CTRL_TYPE_BASE + i * BPM_CTRL_FIELD_STRIDE +: 2]),
        .len_field(breakpoint_control_r[BPM_CTRL_LEN_BASE + i * BPM_CTRL_FIELD_STRIDE +: 2]),
        .ext_en(ext_en),
        .acc(acc),
        .cond(cond[i])
      );
      // Either the task-local or the all-task enable arms the breakpoint.
      assign enabled[i] = breakpoint_control_r[2 * i] | breakpoint_control_r[2 * i + 1];
    end
  endgenerate

  // The exact enable bits take no part in detection.
  assign fire = cond & enabled;
  assign bp_exc = |fire;
  // A guarded debug-register move is stopped before it executes.
  assign reg_exc = dbg_reg_move && breakpoint_control_r[BPM_CTRL_PROTECT];

  assign evt[BPM_EVT_EXC] = bp_exc | reg_exc;
  assign evt[BPM_EVT_REG_ACCESS] = reg_exc;
  assign evt[BPM_EVT_TASK_SWITCH] = task_switch;

  // Breakpoint address registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_BP; i++) begin
        bkpt_addr_r[i] <= 32'h0000_0000;
      end
    end else if (wr_en && is_addr) begin
      bkpt_addr_r[addr_idx] <= pwdata;
    end
  end

  // Control register; hardware clears are applied after a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breakpoint_control_r <= BPM_CTRL_RESET;
    end else begin
      logic [31:0] ctl;
      ctl = breakpoint_control_r;
      if (wr_en && paddr == BPM_OFS_CTRL) begin
        ctl = pwdata & BPM_CTRL_WMASK;
      end
      if (task_switch) begin
        // Global enables are left untouched here.
        ctl = ctl & ~BPM_LOCAL_EN_MASK;
      end
      if (handler_entry) begin
        ctl[BPM_CTRL_PROTECT] = 1'b0;
      end
      breakpoint_control_r <= ctl;
    end
  end

  // Debug status register; hardware sets win over a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_status_reg_r <= BPM_STAT_RESET;
    end else begin
      logic [31:0] st;
      st = debug_status_reg_r;
      if (wr_en && paddr == BPM_OFS_STATUS) begin
        st = pwdata & BPM_STAT_WMASK;
      end
      if (evt[BPM_EVT_EXC]) begin
        // Every met condition is flagged, armed or not.
        st[NUM_BP-1:0] = st[NUM_BP-1:0] | cond;
      end
      if (reg_exc) begin
        st[BPM_STAT_DETECTED] = 1'b1;
      end
      debug_status_reg_r <= st;
    end
  end

  // Configuration register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= BPM_CFG_RESET;
    end else if (wr_en && paddr == BPM_OFS_CFG) begin
      cfg_r <= {31'h0, pwdata[BPM_CFG_EXT_EN]};
    end
  end

  // Exception output and hit vector; the status flag lands on the same edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_exception_r <= 1'b0;
      hit_r <= '0;
      last_addr_r <= 32'h0000_0000;
    end else begin
      debug_exception_r <= bp_exc | reg_exc;
      if (bp_exc | reg_exc) begin
        hit_r <= cond;
      end
      if (bp_exc) begin
        last_addr_r <= acc.addr;
      end
    end
  end

  bpm_evt #(
    .N(BPM_NUM_EVT)
  ) u_evt (
    .pclk(pclk),
    .presetn(presetn),
    .evt(evt),
    .wr_stat(wr_en && paddr == BPM_OFS_EVT_STAT),
    .wr_mask(wr_en && paddr == BPM_OFS_EVT_MASK),
    .wdata(pwdata[BPM_NUM_EVT-1:0]),
    .stat_r(evt_stat),
    .mask_r(evt_mask),
    .irq_r(evt_irq)
  );

  // Read decode.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (is_addr) begin
      rd_mux = bkpt_addr_r[addr_idx];
    end else begin
      unique case (paddr)
        BPM_OFS_STATUS: rd_mux = debug_status_reg_r;
        BPM_OFS_CTRL: rd_mux = breakpoint_control_r;
        BPM_OFS_CFG: rd_mux = cfg_r;
        BPM_OFS_EVT_STAT: rd_mux = {29'h0, evt_stat};
        BPM_OFS_EVT_MASK: rd_mux = {29'h0, evt_mask};
        BPM_OFS_LAST_ADDR: rd_mux = last_addr_r;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // One wait-free access phase: pready rises on the edge after setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable && !pready_r;
      if (psel && !penable) begin
        pslverr_r <= rd_err;
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign debug_exception = debug_exception_r;
  assign bkpt_hit_flag = hit_r;
  assign irq = evt_irq;
endmodule
`default_nettype wire

// *** bpm_pkg.sv ***
/*
  Shared constants and carrier types for the breakpoint match and control block.
  Assumes a 32-bit APB register port and a core pipeline on the same clock.
*/
`default_nettype none
package bpm_pkg;
  localparam int unsigned BPM_NUM_BP = 4;
  localparam int unsigned BPM_NUM_EVT = 3;

  // Register byte offsets.
  localparam logic [7:0] BPM_OFS_ADDR0 = 8'h00;
  localparam logic [7:0] BPM_OFS_ADDR3 = 8'h0c;
  localparam logic [7:0] BPM_OFS_STATUS = 8'h18;
  localparam logic [7:0] BPM_OFS_CTRL = 8'h1c;
  localparam logic [7:0] BPM_OFS_CFG = 8'h20;
  localparam logic [7:0] BPM_OFS_EVT_STAT = 8'h24;
  localparam logic [7:0] BPM_OFS_EVT_MASK = 8'h28;
  localparam logic [7:0] BPM_OFS_LAST_ADDR = 8'h2c;

  // Control register layout.
  localparam int unsigned BPM_CTRL_EXACT_LOCAL = 8;
  localparam int unsigned BPM_CTRL_EXACT_GLOBAL = 9;
  localparam int unsigned BPM_CTRL_PROTECT = 13;
  localparam int unsigned BPM_CTRL_TYPE_BASE = 16;
  localparam int unsigned BPM_CTRL_LEN_BASE = 18;
  localparam int unsigned BPM_CTRL_FIELD_STRIDE = 4;
  localparam logic [31:0] BPM_CTRL_WMASK = 32'hffff23ff;
  localparam logic [31:0] BPM_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BPM_LOCAL_EN_MASK = 32'h0000_0055;

  // Status register layout.
  localparam int unsigned BPM_STAT_DETECTED = 13;
  localparam logic [31:0] BPM_STAT_WMASK = 32'h0000_200f;
  localparam logic [31:0] BPM_STAT_RESET = 32'h0000_0000;

  // Configuration register layout.
  localparam int unsigned BPM_CFG_EXT_EN = 0;
  localparam logic [31:0] BPM_CFG_RESET = 32'h0000_0000;

  // Event bits.
  localparam int unsigned BPM_EVT_EXC = 0;
  localparam int unsigned BPM_EVT_REG_ACCESS = 1;
  localparam int unsigned BPM_EVT_TASK_SWITCH = 2;

  // Access-type field codes.
  localparam logic [1:0] BPM_TYPE_EXEC = 2'h0;
  localparam logic [1:0] BPM_TYPE_WRITE = 2'h1;
  localparam logic [1:0] BPM_TYPE_IO = 2'h2;
  localparam logic [1:0] BPM_TYPE_RDWR = 2'h3;

  // Length field codes.
  localparam logic [1:0] BPM_LEN_1 = 2'h0;
  localparam logic [1:0] BPM_LEN_2 = 2'h1;
  localparam logic [1:0] BPM_LEN_8 = 2'h2;
  localparam logic [1:0] BPM_LEN_4 = 2'h3;

  typedef enum logic [2:0] {
    BPM_ACC_FETCH = 3'h0,
    BPM_ACC_DRD = 3'h1,
    BPM_ACC_DWR = 3'h2,
    BPM_ACC_IORD = 3'h3,
    BPM_ACC_IOWR = 3'h4
  } bpm_acc_kind_e;

  typedef struct packed {
    logic valid;
    bpm_acc_kind_e kind;
    logic [31:0] addr;
    logic [3:0] nbytes;
    logic insn_start;
  } bpm_acc_s;
endpackage
`default_nettype wire

// *** bpm_match.sv ***
/*
  Condition matcher for one breakpoint: access type, range and alignment.
  Assumes the access struct and field values are stable in the cycle they are judged.
*/
`timescale 1ns/1ps
`default_nettype none
module bpm_match
  import bpm_pkg::*;
#(
  parameter bit LEN8_SUPPORTED = 1'b1
) (
  // Breakpoint setup.
  input wire logic [31:0] bp_addr,
  input wire logic [1:0] type_field,
  input wire logic [1:0] len_field,
  input wire logic ext_en,
  // Core access.
  input wire bpm_acc_s acc,
  // Result.
  output logic cond
);
  logic [3:0] span;
  logic [31:0] bp_lo;
  logic [32:0] bp_hi;
  logic [31:0] a_addr;
  logic [32:0] a_hi;
  logic [3:0] n;
  logic kind_ok;
  logic overlap;

  always_comb begin
    unique case (len_field)
      BPM_LEN_2: span = 4'h2;
      BPM_LEN_4: span = 4'h4;
      // An unsupported eight-byte code is undefined; it is treated as one byte.
      BPM_LEN_8: span = LEN8_SUPPORTED ? 4'h8 : 4'h1;
      default: span = 4'h1;
    endcase
  end

  // Low address bits are dropped so ranges are naturally aligned.
  assign bp_lo = bp_addr & ~{28'h0000000, span - 4'h1};
  assign bp_hi = {1'b0, bp_lo} + {29'h0, span - 4'h1};
  assign n = (acc.nbytes == 4'h0) ? 4'h1 : acc.nbytes;
  // Port numbers are widened with zeros before comparison.
  assign a_addr = (acc.kind == BPM_ACC_IORD || acc.kind == BPM_ACC_IOWR) ?
    {16'h0000, acc.addr[15:0]} : acc.addr;
  assign a_hi = {1'b0, a_addr} + {29'h0, n - 4'h1};
  // Any touched byte inside the range hits.
  assign overlap = ({1'b0, a_addr} <= bp_hi) && (a_hi >= {1'b0, bp_lo});

  always_comb begin
    unique case (type_field)
      BPM_TYPE_EXEC: kind_ok = (acc.kind == BPM_ACC_FETCH) && acc.insn_start;
      BPM_TYPE_WRITE: kind_ok = (acc.kind == BPM_ACC_DWR);
      // The I/O code is undefined without extensions; it then never hits.
      BPM_TYPE_IO: kind_ok = ext_en && (acc.kind == BPM_ACC_IORD || acc.kind == BPM_ACC_IOWR);
      default: kind_ok = (acc.kind == BPM_ACC_DRD) || (acc.kind == BPM_ACC_DWR);
    endcase
  end

  // Instruction breakpoints compare the exact first byte only.
  assign cond = acc.valid && kind_ok &&
    ((type_field == BPM_TYPE_EXEC) ? (acc.addr == bp_addr) : overlap);
endmodule
`default_nettype wire

// *** bpm_evt.sv ***
/*
  Sticky event status with write-one-to-clear, mask and one level interrupt.
  Assumes event pulses and register writes come on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bpm_evt
  import bpm_pkg::*;
#(
  parameter int unsigned N = BPM_NUM_EVT
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Events and software access.
  input wire logic [N-1:0] evt,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [N-1:0] wdata,
  // State.
  output logic [N-1:0] stat_r,
  output logic [N-1:0] mask_r,
  output logic irq_r
);
  logic [N-1:0] stat_nxt;
  logic [N-1:0] mask_nxt;

  // A new event in the clearing cycle survives the clear.
  assign stat_nxt = (wr_stat ? (stat_r & ~wdata) : stat_r) | evt;
  assign mask_nxt = wr_mask ? wdata : mask_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end
endmodule
`default_nettype wire

// *** bpm_checker.sv ***
/*
  Port assertions for the breakpoint match and control block.
  Assumes the bind below attaches it to bpm_top with the same NUM_BP.
*/
`timescale 1ns/1ps
`default_nettype none
module bpm_checker
  import bpm_pkg::*;
#(
  parameter int unsigned NUM_BP = BPM_NUM_BP
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and results.
  input wire bpm_acc_s acc,
  input wire logic task_switch,
  input wire logic dbg_reg_move,
  input wire logic handler_entry,
  input wire logic debug_exception,
  input wire logic [NUM_BP-1:0] bkpt_hit_flag,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic prot_r;
  logic cause_w;
  assign cause_w = debug_exception || task_switch || (psel && penable && pwrite);
  // A shadow of the protect bit lets a move be judged without seeing the register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r <= 1'b0;
    end else if (handler_entry) begin
      prot_r <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == BPM_OFS_CTRL) begin
      prot_r <= pwdata[BPM_CTRL_PROTECT];
    end
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_done;
    pready ##1 !(psel && !penable);
  endsequence
  answer_next_a: assert property (apb_setup |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_unmapped_a: assert property (psel && !penable && paddr > 8'h2c |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  rdata_hold_a: assert property (apb_done |-> $stable(prdata)) else $error("read data moved");
  exc_cause_a: assert property (debug_exception |-> $past(acc.valid || dbg_reg_move))
    else $error("exception without cause");
  flag_hold_a: assert property (!debug_exception |-> $stable(bkpt_hit_flag))
    else $error("hit flags changed without exception");
  prot_move_a: assert property (prot_r && dbg_reg_move && !handler_entry |=> debug_exception)
    else $error("protected move not flagged");
  free_move_a: assert property (!prot_r && dbg_reg_move && !acc.valid |=> !debug_exception)
    else $error("unprotected move flagged");
  fetch_mid_a: assert property (acc.valid && acc.kind == BPM_ACC_FETCH && !acc.insn_start
    && !dbg_reg_move |=> !debug_exception) else $error("fetch inside instruction matched");
  irq_cause_a: assert property ($rose(irq) |-> cause_w || $past(cause_w) || $past(cause_w, 2))
    else $error("interrupt rose without event");
endmodule
bind bpm_top bpm_checker #(.NUM_BP(NUM_BP)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .acc(acc), .task_switch(task_switch), .dbg_reg_move(dbg_reg_move),
  .handler_entry(handler_entry), .debug_exception(debug_exception), .bkpt_hit_flag(bkpt_hit_flag), .irq(irq));
`default_nettype wire

// *** bpm_core_model.sv ***
/*
  Behavioural core pipeline issuing accesses and pulses on command.
  Assumes the bench calls drive just after a rising edge of pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module bpm_core_model
  import bpm_pkg::*;
(
  // Clock and exception.
  input wire logic pclk,
  input wire logic debug_exception,
  // Core outputs.
  output var bpm_acc_s acc,
  output logic task_switch,
  output logic dbg_reg_move,
  output logic handler_entry
);
  initial begin
    acc = '0;
    task_switch = 1'b0;
    dbg_reg_move = 1'b0;
    handler_entry = 1'b0;
  end
  // The handler is entered after every exception, as a real core would do.
  always @(posedge pclk) handler_entry <= debug_exception;
  // A released access shows an inverted address so stale values never match by luck.
  task automatic drive(input int w, input logic [2:0] k, input logic [31:0] a, input logic [3:0] n,
                       input logic s);
    if (w == 0) acc <= '{1'b1, bpm_acc_kind_e'(k), a, n, s};
    task_switch <= (w == 1);
    dbg_reg_move <= (w == 2);
    @(posedge pclk);
    acc <= '{1'b0, bpm_acc_kind_e'(k), ~a, n, 1'b0};
    task_switch <= 1'b0;
    dbg_reg_move <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bpm_top_tb.sv ***
/*
  Self-checking bench for bpm_top over APB and the core model.
  Assumes bpm_core_model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module bpm_top_tb;
  import bpm_pkg::*;
  typedef struct {logic [1:0] ty, ln; logic [31:0] ba, aa; logic [2:0] k; logic [3:0] n; logic ex;} bpm_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic task_switch, dbg_reg_move, handler_entry, debug_exception, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] bkpt_hit_flag;
  bpm_acc_s acc;
  int n_errors = 0;
  int tests_run = 0;
  bpm_row_s rows [14] = '{
    '{3, 0, 32'ha0001, 32'ha0001, 1, 1, 1}, '{3, 0, 32'ha0001, 32'ha0000, 1, 1, 0},
    '{1, 0, 32'ha0002, 32'ha0002, 2, 2, 1}, '{1, 0, 32'ha0002, 32'ha0002, 1, 1, 0},
    '{3, 1, 32'hb0002, 32'hb0001, 1, 4, 1}, '{3, 1, 32'hb0002, 32'hb0000, 2, 2, 0},
    '{1, 3, 32'hc0000, 32'hc0003, 2, 1, 1}, '{1, 3, 32'hc0000, 32'hc0004, 2, 4, 0},
    '{1, 3, 32'hc0002, 32'hc0000, 2, 1, 1}, '{2, 0, 32'h1234, 32'habcd1234, 3, 1, 1},
    '{2, 0, 32'hab001234, 32'h1234, 4, 2, 0}, '{2, 0, 32'h1234, 32'h1234, 1, 1, 0},
    '{3, 2, 32'h800, 32'h807, 1, 1, 1}, '{3, 2, 32'h800, 32'h808, 2, 1, 0}};
  logic [7:0] ofs [7] = '{BPM_OFS_ADDR0, BPM_OFS_ADDR3, BPM_OFS_STATUS, BPM_OFS_CTRL, BPM_OFS_CFG,
                          BPM_OFS_EVT_STAT, BPM_OFS_EVT_MASK};
  bpm_top #(.LEN8_SUPPORTED(1'b1), .NUM_BP(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc(acc), .task_switch(task_switch), .dbg_reg_move(dbg_reg_move),
    .handler_entry(handler_entry), .debug_exception(debug_exception), .bkpt_hit_flag(bkpt_hit_flag), .irq(irq));
  bpm_core_model core (.pclk(pclk), .debug_exception(debug_exception), .acc(acc), .task_switch(task_switch),
    .dbg_reg_move(dbg_reg_move), .handler_entry(handler_entry));
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // An idle cycle follows each transfer so no strobe is assigned twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  task automatic act(input int w, input logic [2:0] k, input logic [31:0] a, input logic [3:0] n,
                     input logic s, input logic ex, input logic [3:0] f);
    core.drive(w, k, a, n, s);
    #1;
    chk(debug_exception, ex);
    if (w == 0 && ex) chk(bkpt_hit_flag, f);
    @(posedge pclk);
  endtask
  task automatic lvl(input logic e);
    @(posedge pclk);
    #1;
    chk(irq, e);
    @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, BPM_OFS_CFG, 32'h1);
    foreach (rows[i]) begin
      apb(1'b1, BPM_OFS_ADDR0, rows[i].ba);
      apb(1'b1, BPM_OFS_CTRL, 32'h2 | (32'({rows[i].ln, rows[i].ty}) << BPM_CTRL_TYPE_BASE));
      act(0, rows[i].k, rows[i].aa, rows[i].n, 1'b1, rows[i].ex, 4'h1);
    end
    for (int i = 0; i < 4; i++) apb(1'b1, BPM_OFS_ADDR0 + 8'(4 * i), 32'h5000);
    apb(1'b1, BPM_OFS_CTRL, 32'h33330055);
    act(0, 3'h1, 32'h5000, 4'h1, 1'b1, 1'b1, 4'hf);
    act(1, 3'h0, 32'h0, 4'h1, 1'b0, 1'b0, 4'h0);
    rdc(BPM_OFS_CTRL, 32'h33330000);
    act(0, 3'h1, 32'h5000, 4'h1, 1'b1, 1'b0, 4'h0);
    apb(1'b1, BPM_OFS_CTRL, 32'h33330302);
    act(1, 3'h0, 32'h0, 4'h1, 1'b0, 1'b0, 4'h0);
    rdc(BPM_OFS_CTRL, 32'h33330302);
    act(0, 3'h2, 32'h5000, 4'h1, 1'b1, 1'b1, 4'hf);
    apb(1'b1, BPM_OFS_CTRL, 32'h33330300);
    act(0, 3'h1, 32'h5000, 4'h1, 1'b1, 1'b0, 4'h0);
    apb(1'b1, BPM_OFS_CTRL, 32'h2000);
    act(2, 3'h0, 32'h0, 4'h1, 1'b0, 1'b1, 4'h0);
    rdc(BPM_OFS_STATUS, 32'h200f);
    apb(1'b1, BPM_OFS_STATUS, 32'h0);
    rdc(BPM_OFS_STATUS, 32'h0);
    rdc(BPM_OFS_CTRL, 32'h0);
    act(2, 3'h0, 32'h0, 4'h1, 1'b0, 1'b0, 4'h0);
    rdc(BPM_OFS_EVT_STAT, 32'h7);
    apb(1'b1, BPM_OFS_EVT_STAT, 32'h7);
    rdc(BPM_OFS_EVT_STAT, 32'h0);
    // Execute breakpoint with length zero, as software must program it.
    apb(1'b1, BPM_OFS_CTRL, 32'h2);
    act(0, 3'h0, 32'h5000, 4'h1, 1'b0, 1'b0, 4'h0);
    act(0, 3'h0, 32'h5000, 4'h1, 1'b1, 1'b1, 4'hf);
    lvl(1'b0);
    rdc(BPM_OFS_LAST_ADDR, 32'h5000);
    apb(1'b1, BPM_OFS_EVT_MASK, 32'h1);
    lvl(1'b1);
    apb(1'b1, BPM_OFS_EVT_STAT, 32'h1);
    lvl(1'b0);
    apb(1'b1, BPM_OFS_CFG, 32'h0);
    apb(1'b1, BPM_OFS_CTRL, 32'h20002);
    act(0, 3'h3, 32'h5000, 4'h1, 1'b1, 1'b0, 4'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd_e, 1'b1);
    chk(rd_v, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
